// ---- pio_ports.sv ----
// Programmable I/O port bank: ports 0 to 10, direction, latch, pull-up, format, muxing.
// Assumes synchronous pin inputs, a byte register port, and a bus controller that
// flags pins it owns in expansion modes.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pio_ports #(
  parameter int NP = 11
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [9:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [7:0]        regRdata,
  // Pins
  input  wire logic [NP*8-1:0]   pinIn,
  output logic      [NP*8-1:0]   pinOut,
  output logic      [NP*8-1:0]   pinOe,
  output logic      [NP*8-1:0]   pinPullup,
  input  wire logic              nmiLevel,
  // Bus controller and peripherals
  input  wire logic [NP*8-1:0]   busOwned,
  input  wire logic [NP*8-1:0]   periphOutA,
  input  wire logic [NP*8-1:0]   periphOutB,
  input  wire logic [NP*8-1:0]   periphOutC,
  input  wire logic [NP*8-1:0]   periphOutD,
  output logic      [NP*8-1:0]   periphIn,
  output logic      [3:0]        keyInput
);
  localparam int NB = NP * 8;
  typedef struct packed {
    logic [1:0]    rstSync;
    logic [NB-1:0] dir;
    logic [NB-1:0] latch;
    logic [NB-1:0] selA;
    logic [NB-1:0] selB;
    logic [7:0]    selC;
    logic [7:0]    selC3;
    logic [7:0]    selD;
    logic [23:0]   pull;
    logic [7:0]    format;
    logic [7:0]    protect;
    logic [7:0]    rdata;
    logic [NB-1:0] out;
    logic [NB-1:0] oe;
    logic [NB-1:0] pu;
    logic [NB-1:0] pin;
    logic [3:0]    key;
    logic [NB-1:0] periph;
  } pio_state_s;
  pio_state_s st_q;
  pio_state_s st_d;
  logic       rstInt_n;
  logic       syncA_q;
  logic       syncB_q;

  // Reset released through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= 1'b1;
      syncB_q <= syncA_q;
    end
  end
  assign rstInt_n = syncB_q;

  function automatic logic [7:0] byteOf(input logic [NB-1:0] v, input int p);
    byteOf = v[p*8 +: 8];
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.rstSync = 2'b11;
    // Register writes
    if (regWrite) begin
      for (int p = 0; p < NP; p++) begin
        if (regAddr == pio_pkg::OFS_DIR[p]) begin
          if (p != 9 || st_q.protect[pio_pkg::UNLOCK_BIT]) begin
            st_d.dir[p*8 +: 8] = regWdata;
          end
          if (p == 9) begin
            st_d.protect[pio_pkg::UNLOCK_BIT] = 1'b0;
          end
        end
        if (regAddr == pio_pkg::OFS_DATA[p]) begin
          st_d.latch[p*8 +: 8] = regWdata;
        end
      end
      for (int j = 0; j < 4; j++) begin
        if (regAddr == pio_pkg::OFS_SELA + 10'(j)) begin
          st_d.selA[(6+j)*8 +: 8] = regWdata;
        end
        if (regAddr == pio_pkg::OFS_SELB + 10'(j)) begin
          st_d.selB[(6+j)*8 +: 8] = regWdata;
        end
      end
      if (regAddr == pio_pkg::OFS_SELC) begin
        st_d.selC = regWdata;
      end
      if (regAddr == pio_pkg::OFS_SELC3) begin
        st_d.selC3 = regWdata;
      end
      if (regAddr == pio_pkg::OFS_SELD) begin
        st_d.selD = regWdata;
      end
      if (regAddr == pio_pkg::OFS_PULL) begin
        st_d.pull[7:0] = regWdata;
      end
      if (regAddr == pio_pkg::OFS_PULL + 10'h001) begin
        st_d.pull[15:8] = regWdata;
      end
      if (regAddr == pio_pkg::OFS_PULL3) begin
        st_d.pull[23:16] = regWdata;
      end
      if (regAddr == pio_pkg::OFS_FORMAT) begin
        st_d.format = regWdata;
      end
      if (regAddr == pio_pkg::OFS_PROTECT) begin
        st_d.protect = regWdata;
      end
    end
    // Input-only pin never has a direction bit
    st_d.dir[pio_pkg::NMI_PORT*8 + pio_pkg::NMI_BIT] = 1'b0;
    // Register reads
    st_d.rdata = 8'h00;
    if (regRead) begin
      for (int p = 0; p < NP; p++) begin
        if (regAddr == pio_pkg::OFS_DIR[p]) begin
          st_d.rdata = byteOf(st_q.dir, p);
        end
        if (regAddr == pio_pkg::OFS_DATA[p]) begin
          st_d.rdata = byteOf(st_q.pin, p);
          if (p == pio_pkg::NMI_PORT) begin
            st_d.rdata[pio_pkg::NMI_BIT] = nmiLevel;
          end
        end
      end
      for (int j = 0; j < 4; j++) begin
        if (regAddr == pio_pkg::OFS_SELA + 10'(j)) begin
          st_d.rdata = byteOf(st_q.selA, 6 + j);
        end
        if (regAddr == pio_pkg::OFS_SELB + 10'(j)) begin
          st_d.rdata = byteOf(st_q.selB, 6 + j);
        end
      end
      if (regAddr == pio_pkg::OFS_SELC) begin
        st_d.rdata = st_q.selC;
      end
      if (regAddr == pio_pkg::OFS_SELC3) begin
        st_d.rdata = st_q.selC3;
      end
      if (regAddr == pio_pkg::OFS_SELD) begin
        st_d.rdata = st_q.selD;
      end
      if (regAddr == pio_pkg::OFS_PULL) begin
        st_d.rdata = st_q.pull[7:0];
      end
      if (regAddr == pio_pkg::OFS_PULL + 10'h001) begin
        st_d.rdata = st_q.pull[15:8];
      end
      if (regAddr == pio_pkg::OFS_PULL3) begin
        st_d.rdata = st_q.pull[23:16];
      end
      if (regAddr == pio_pkg::OFS_FORMAT) begin
        st_d.rdata = st_q.format;
      end
      if (regAddr == pio_pkg::OFS_PROTECT) begin
        st_d.rdata = st_q.protect;
      end
    end
    // Pin drivers
    st_d.pin = pinIn;
    for (int b = 0; b < NB; b++) begin
      logic src;
      src = st_q.latch[b];
      if (st_q.selA[b]) begin
        // Later selects override earlier ones for shared pins
        src = periphOutA[b];
        if (st_q.selB[b]) begin
          src = periphOutB[b];
        end
        if (b >= 56 && b < 64 && st_q.selC[b-56]) begin
          src = periphOutC[b];
        end
        if (b >= 72 && b < 80 && st_q.selC3[b-72]) begin
          src = periphOutC[b];
        end
        if (b >= 56 && b < 64 && st_q.selD[b-56]) begin
          src = periphOutD[b];
        end
      end
      st_d.out[b] = src;
      st_d.oe[b] = st_q.dir[b] | st_q.selA[b];
      // Open-drain on port 1: high side off
      if (b >= 8 && b < 16 && st_q.format[pio_pkg::OPEN_DRAIN_BIT] && src) begin
        st_d.oe[b] = 1'b0;
      end
      st_d.pu[b] = st_q.pull[b/4] & ~st_q.dir[b] & ~st_q.selA[b];
      if (busOwned[b]) begin
        // Bus controller drives these pins; port logic stays off
        st_d.out[b] = 1'b0;
        st_d.oe[b] = 1'b0;
        st_d.pu[b] = 1'b0;
      end
    end
    st_d.pu[pio_pkg::NMI_PORT*8 + pio_pkg::NMI_BIT] = 1'b0;
    st_d.oe[pio_pkg::NMI_PORT*8 + pio_pkg::NMI_BIT] = 1'b0;
    // Key inputs frozen while isolated
    if (!st_q.selC[pio_pkg::KEY_ISO_BIT]) begin
      st_d.key = pinIn[84 +: 4];
    end
    // Peripheral inputs: isolated analog pins read as low
    st_d.periph = pinIn;
    for (int k = 0; k < 4; k++) begin
      if (st_q.selB[75 + k]) begin
        st_d.periph[75 + k] = 1'b0;
      end
    end
    if (st_q.selC[pio_pkg::KEY_ISO_BIT]) begin
      st_d.periph[84 +: 4] = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign periphIn  = st_q.periph;
  assign regRdata  = st_q.rdata;
  assign pinOut    = st_q.out;
  assign pinOe     = st_q.oe;
  assign pinPullup = st_q.pu;
  assign keyInput  = st_q.key;

  // Direction and drive

  a_dir_output: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (!busOwned[0] && !st_q.selA[0]) |=> (pinOe[0] == $past(st_q.dir[0])))
    else $error("direction does not steer drive");

  a_dir_input: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (!st_q.dir[4] && !st_q.selA[4]) |=> !pinOe[4])
    else $error("input pin driven");

  a_dir_write: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regWrite && regAddr == pio_pkg::OFS_DIR[0]) |=> (st_q.dir[7:0] == $past(regWdata)))
    else $error("direction write lost");

  a_dir_readback: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regRead && regAddr == pio_pkg::OFS_DIR[0]) |=> (regRdata == $past(st_q.dir[7:0])))
    else $error("direction readback wrong");

  a_nmi_nodir: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    !st_q.dir[69])
    else $error("input-only pin has direction");

  // Latch and readback

  a_latch_write: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regWrite && regAddr == pio_pkg::OFS_DATA[1]) |=> (st_q.latch[15:8] == $past(regWdata)))
    else $error("latch write lost");

  a_latch_out: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (!busOwned[2] && !st_q.selA[2]) |=> (pinOut[2] == $past(st_q.latch[2])))
    else $error("latch does not reach pin");

  a_read_pins: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regRead && regAddr == pio_pkg::OFS_DATA[0]) |=> (regRdata == $past(pinIn[7:0], 2)))
    else $error("data read is not pin state");

  a_read_idle: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    !regRead |=> (regRdata == 8'h00))
    else $error("read data outside read cycle");

  a_nmi_read: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regRead && regAddr == pio_pkg::OFS_DATA[8]) |=> (regRdata[5] == $past(nmiLevel)))
    else $error("nonmaskable level not reflected");

  // Pull-up

  a_pull_input: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    st_q.dir[3] |=> !pinPullup[3])
    else $error("pull-up on output");

  a_pull_group: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (!st_q.dir[5] && !st_q.selA[5] && st_q.pull[1] && !busOwned[5]) |=> pinPullup[5])
    else $error("enabled input not pulled up");

  a_pull_off: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    !st_q.pull[0] |=> !pinPullup[0])
    else $error("pull-up without group bit");

  a_nmi_nopull: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    !pinPullup[69] && !pinOe[69])
    else $error("input-only pin driven or pulled");

  // Bus ownership

  a_bus_owned: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    busOwned[1] |=> !pinOe[1])
    else $error("bus pin driven by port");

  a_bus_nopull: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    busOwned[2] |=> !pinPullup[2])
    else $error("bus pin pulled by port");

  // Output format

  a_open_drain: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (st_q.format[0] && st_q.out[8] && !busOwned[8]) |-> !pinOe[8] || $past(!st_q.format[0]))
    else $error("open-drain drives high");

  a_cmos_drive: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (!st_q.format[0] && st_q.dir[9] && !st_q.selA[9] && !busOwned[9]) |=> pinOe[9])
    else $error("cmos output not driven");

  // Function selects

  a_sel_periph: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (st_q.selA[48] && !st_q.selB[48] && !busOwned[48]) |=> (pinOut[48] == $past(periphOutA[48])))
    else $error("peripheral A not on pin");

  a_sel_drive: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (st_q.selA[50] && !busOwned[50]) |=> pinOe[50])
    else $error("peripheral pin not driven");

  a_sel_b: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (st_q.selA[49] && st_q.selB[49] && !busOwned[49]) |=> (pinOut[49] == $past(periphOutB[49])))
    else $error("peripheral B not on pin");

  // Write protection of port 9 direction

  a_dir9_lock: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regWrite && regAddr == pio_pkg::OFS_DIR[9] && !st_q.protect[2]) |=> $stable(st_q.dir[79:72]))
    else $error("locked direction written");

  a_dir9_open: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regWrite && regAddr == pio_pkg::OFS_DIR[9] && st_q.protect[2])
    |=> (st_q.dir[79:72] == $past(regWdata)))
    else $error("unlocked direction write lost");

  a_unlock_once: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    (regWrite && regAddr == pio_pkg::OFS_DIR[9]) |=> !st_q.protect[2])
    else $error("unlock survives direction write");

  // Analog isolation

  a_iso_block: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    st_q.selB[75] |=> !periphIn[75])
    else $error("isolated pin reaches peripheral");

  a_iso_pass: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    !st_q.selB[76] |=> (periphIn[76] == $past(pinIn[76])))
    else $error("non-isolated pin blocked");

  a_key_freeze: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    st_q.selC[7] |=> $stable(keyInput))
    else $error("key input changed while isolated");

  a_key_live: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
    !st_q.selC[7] |=> (keyInput == $past(pinIn[87:84])))
    else $error("key input not following pins");
endmodule
`default_nettype wire

// ---- pio_pkg.sv ----
// Package for the programmable I/O port bank: register offsets, resets, widths.
// Assumes a byte-wide register port with 10-bit addresses.
package pio_pkg;
  localparam int NPORTS = 11;
  localparam logic [9:0] OFS_DIR [0:10] = '{10'h3E2, 10'h3E3, 10'h3E6, 10'h3E7, 10'h3EA,
    10'h3EB, 10'h3C2, 10'h3C3, 10'h3C6, 10'h3C7, 10'h3CA};
  localparam logic [9:0] OFS_DATA [0:10] = '{10'h3E0, 10'h3E1, 10'h3E4, 10'h3E5, 10'h3E8,
    10'h3E9, 10'h3C0, 10'h3C1, 10'h3C4, 10'h3C5, 10'h3C8};
  localparam logic [9:0] OFS_SELA    = 10'h3B0;
  localparam logic [9:0] OFS_SELB    = 10'h3B4;
  localparam logic [9:0] OFS_SELC    = 10'h3AF;
  localparam logic [9:0] OFS_SELC3   = 10'h3AE;
  localparam logic [9:0] OFS_SELD    = 10'h3A7;
  localparam logic [9:0] OFS_PULL    = 10'h3F0;
  localparam logic [9:0] OFS_PULL3   = 10'h3DA;
  localparam logic [9:0] OFS_FORMAT  = 10'h3FF;
  localparam logic [9:0] OFS_PROTECT = 10'h00A;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic [7:0] RST_REG     = 8'h00;
  localparam int NMI_PORT = 8;
  localparam int NMI_BIT  = 5;
  localparam int UNLOCK_BIT  = 2;
  localparam int OPEN_DRAIN_BIT = 0;
  localparam int KEY_ISO_BIT = 7;
  localparam int NGROUPS = 22;
endpackage

// ---- pio_pins_model.sv ----
// Behavioural model of the devices wired to the port pins.
// Assumes the bench chooses which pins it drives from outside, and to what.
`timescale 1ns/1ps
`default_nettype none
module pio_pins_model #(
  parameter int W = 88
) (
  // Clock
  input  wire logic         clk_sys,
  // Device side
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pinPullup,
  output logic      [W-1:0] pinIn,
  // Outside drivers
  input  wire logic [W-1:0] extVal,
  input  wire logic [W-1:0] extEn
);
  logic [W-1:0] floatQ = '0;

  // Undriven pins without pull-up wander every cycle
  always @(posedge clk_sys) floatQ <= ~floatQ;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extVal[i];
      else if (pinPullup[i]) pinIn[i] = 1'b1;
      else pinIn[i] = floatQ[i];
    end
  end
endmodule
`default_nettype wire

// ---- programmable_io_ports_tb_top.sv ----
// Self-checking bench for the port bank, driven over its register port.
// Assumes pio_pkg, pio_ports and pio_pins_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module programmable_io_ports_tb_top;
  logic        clk_sys  = 1'b0;
  logic        reset_n  = 1'b0;
  logic [9:0]  regAddr  = '0;
  logic [7:0]  regWdata = '0;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic        nmiLevel = 1'b0;
  logic [87:0] busOwned = '0;
  logic [87:0] periphA  = '0;
  logic [87:0] extVal   = '0;
  logic [87:0] extEn    = '0;
  logic [7:0]  regRdata;
  logic [87:0] pinIn, pinOut, pinOe, pinPullup, periphIn;
  logic [3:0]  keyInput;
  int          errorCnt = 0;
  int          cmpCount = 0;
  int          cycles   = 0;

  always #5 clk_sys = ~clk_sys;

  pio_ports #(.NP(11)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
    .nmiLevel(nmiLevel), .busOwned(busOwned), .periphOutA(periphA), .periphOutB('0),
    .periphOutC('0), .periphOutD('0), .periphIn(periphIn), .keyInput(keyInput));

  pio_pins_model #(.W(88)) pins (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullup(pinPullup), .pinIn(pinIn), .extVal(extVal), .extEn(extEn));

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdChk(input logic [9:0] a, input logic [7:0] exp);
    regAddr  <= a;
    regRead  <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    chk($sformatf("reg %h", a), exp, regRdata);
    @(posedge clk_sys);
  endtask

  // Cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errorCnt++;
      wrapUp();
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < pio_pkg::NPORTS; i++) rdChk(pio_pkg::OFS_DIR[i], 8'h00);
    chk("port0 enables", 8'h00, pinOe[7:0]);
    rdChk(10'h3CC, 8'h00);
    $display("reset test done");
    // Low nibble driven, high nibble read from outside
    extEn[7:4]  <= 4'hF;
    extVal[7:4] <= 4'h3;
    wr(pio_pkg::OFS_DIR[0], 8'h0F);
    wr(pio_pkg::OFS_DATA[0], 8'hA5);
    wr(pio_pkg::OFS_PULL, 8'h03);
    idle(4);
    chk("port0 enables", 8'h0F, pinOe[7:0]);
    chk("port0 levels", 8'h05, pinOut[7:0] & 8'h0F);
    chk("port0 pullups", 8'hF0, pinPullup[7:0]);
    rdChk(pio_pkg::OFS_DIR[0], 8'h0F);
    rdChk(pio_pkg::OFS_DATA[0], 8'h35);
    busOwned[7:0] <= 8'hFF;
    idle(3);
    chk("owned enables", 8'h00, pinOe[7:0]);
    chk("owned pullups", 8'h00, pinPullup[7:0]);
    busOwned[7:0] <= 8'h00;
    wr(pio_pkg::OFS_PULL, 8'h00);
    idle(3);
    chk("bus pullups cleared", 8'h00, pinPullup[7:0]);
    $display("port0 test done");
    // Open-drain format on port 1
    wr(pio_pkg::OFS_DIR[1], 8'hFF);
    wr(pio_pkg::OFS_DATA[1], 8'hF0);
    wr(pio_pkg::OFS_FORMAT, 8'h01);
    idle(3);
    chk("port1 open drain", 8'h0F, pinOe[15:8]);
    wr(pio_pkg::OFS_FORMAT, 8'h00);
    idle(3);
    chk("port1 cmos", 8'hFF, pinOe[15:8]);
    $display("format test done");
    // Port 8 and its input-only pin
    extEn[71:64] <= 8'hFF;
    nmiLevel     <= 1'b1;
    wr(pio_pkg::OFS_DIR[8], 8'h0F);
    wr(pio_pkg::OFS_PULL3, 8'h02);
    idle(4);
    rdChk(pio_pkg::OFS_DATA[8], 8'h20);
    rdChk(pio_pkg::OFS_DIR[8], 8'h0F);
    chk("port8 pullups", 8'hD0, pinPullup[71:64]);
    nmiLevel <= 1'b0;
    idle(4);
    rdChk(pio_pkg::OFS_DATA[8], 8'h00);
    $display("port8 test done");
    // Port 9 direction needs the unlock bit first
    wr(pio_pkg::OFS_DIR[9], 8'h55);
    idle(1);
    rdChk(pio_pkg::OFS_DIR[9], 8'h00);
    wr(pio_pkg::OFS_PROTECT, 8'h04);
    wr(pio_pkg::OFS_DIR[9], 8'h55);
    wr(pio_pkg::OFS_DIR[9], 8'hAA);
    idle(1);
    rdChk(pio_pkg::OFS_DIR[9], 8'h55);
    $display("protect test done");
    // Analog isolation of port 9 bits 3 to 6
    extEn[79:72]  <= 8'hFF;
    extVal[79:72] <= 8'hFF;
    idle(4);
    chk("port9 inputs", 8'hAA, periphIn[79:72]);
    wr(pio_pkg::OFS_SELB + 10'h003, 8'h78);
    idle(4);
    chk("port9 isolated", 8'h82, periphIn[79:72]);
    // Key inputs freeze while isolated
    extEn[87:80]  <= 8'hFF;
    extVal[87:84] <= 4'h5;
    idle(4);
    chk("key inputs", 8'h05, {4'h0, keyInput});
    wr(pio_pkg::OFS_SELC, 8'h80);
    extVal[87:84] <= 4'hA;
    idle(4);
    chk("key frozen", 8'h05, {4'h0, keyInput});
    wr(pio_pkg::OFS_SELC, 8'h00);
    idle(4);
    chk("key live", 8'h0A, {4'h0, keyInput});
    $display("isolation test done");
    // Peripheral output replaces the latch on port 6
    periphA[55:48] <= 8'h3C;
    wr(pio_pkg::OFS_DIR[6], 8'hFF);
    wr(pio_pkg::OFS_SELA, 8'hFF);
    idle(3);
    chk("port6 peripheral", 8'h3C, pinOut[55:48]);
    wr(pio_pkg::OFS_SELA, 8'h00);
    idle(3);
    chk("port6 latch", 8'h00, pinOut[55:48]);
    $display("select test done");
    wrapUp();
  end
endmodule
`default_nettype wire
